/* File: logic/timer16_pkg.sv */
// Purpose: constants and types shared by the 16-bit capture/compare timer core
// Assumes: Avalon-MM slave with 32-bit data and word-aligned byte addresses
// Notes:   mode, control and edge registers use a layout local to this core
package timer16_pkg;

   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam int CNT_W  = 16;

   localparam logic [ADDR_W-1:0] OFS_COUNT   = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_CAPCMP  = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_MODE    = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_CCCTRL  = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_EDGE    = 5'h10;

   // mode_control_reg fields
   localparam int MODE_OPEN_LO_POS  = 2;
   localparam int MODE_OPEN_HI_POS  = 3;
   localparam int MODE_ONESHOT_POS  = 4;
   localparam int MODE_TRIGGER_POS  = 6;
   // cap_cmp_control_reg fields
   localparam int CC_CAPTURE_POS    = 0;
   localparam int CC_SOURCE_POS     = 1;
   // prescaler_edge_reg fields
   localparam int EDGE_CLKSEL_POS   = 0;
   localparam int EDGE_IN0_LO_POS   = 4;
   localparam int EDGE_IN1_LO_POS   = 6;

   localparam logic [CNT_W-1:0] CNT_RESET    = 16'h0000;
   localparam logic [CNT_W-1:0] CAPCMP_RESET = 16'h0000;
   localparam logic [7:0]       MODE_RESET   = 8'h00;
   localparam logic [1:0]       CCCTRL_RESET = 2'h0;
   localparam logic [7:0]       EDGE_RESET   = 8'h00;

   typedef enum logic [1:0] {
      OP_STOP       = 2'b00,
      OP_FREE_RUN   = 2'b01,
      OP_CLR_ON_IN0 = 2'b10,
      OP_CLR_ON_CMP = 2'b11
   } op_mode_type;

   typedef enum logic [1:0] {
      EDGE_FALL = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_BAD  = 2'b10,
      EDGE_BOTH = 2'b11
   } edge_sel_type;

   typedef struct packed {
      logic              read;
      logic              write;
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] writedata;
      logic [3:0]        byteenable;
   } avs_req_type;

endpackage

/* File: logic/timer16_capture_compare_core.sv */
// Purpose: 16-bit up-counter with one capture/compare register, Avalon-MM slave
// Assumes: timer pins are synchronous to clk; one access takes two cycles
// Notes:   count clock is clk itself or the valid edge of input 0
`timescale 1ns/1ns

module timer16_capture_compare_core
   import timer16_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire avs_req_type       avs_req,
   output      logic [DATA_W-1:0] avs_readdata,
   output      logic              avs_waitrequest,
   input  wire logic              timer_in_pin0,
   input  wire logic              timer_in_pin1,
   output      logic              first_match_irq
);

   logic [CNT_W-1:0]  count_value_r;
   logic [CNT_W-1:0]  count_value_nxt;
   logic [CNT_W-1:0]  first_cap_cmp_reg_r;
   logic [CNT_W-1:0]  first_cap_cmp_reg_nxt;
   logic [7:0]        mode_control_reg_r;
   logic [1:0]        cap_cmp_control_reg_r;
   logic [7:0]        prescaler_edge_reg_r;
   logic              waitrequest_r;
   logic [DATA_W-1:0] readdata_r;
   logic [DATA_W-1:0] readdata_nxt;
   logic              irq_r;
   logic              pin0_prev_r;
   logic              pin1_prev_r;
   logic              tick_pending_r;
   logic              fresh_start_r;

   // ---- bus decode ----
   logic              req_any;
   logic              accept;
   logic              wr_accept;
   logic              rd_first;
   logic              sel_count;
   logic              sel_capcmp;
   logic              sel_mode;
   logic              sel_ccctrl;
   logic              sel_edge;
   logic              full_half;
   logic              wr_capcmp;
   logic              wr_mode;
   logic              wr_ccctrl;
   logic              wr_edge;
   logic              oneshot_trigger_bit;

   assign req_any    = avs_req.read | avs_req.write;
   assign accept     = req_any & ~waitrequest_r;
   assign wr_accept  = avs_req.write & ~waitrequest_r;
   assign rd_first   = avs_req.read & waitrequest_r;
   assign sel_count  = (avs_req.address == OFS_COUNT);
   assign sel_capcmp = (avs_req.address == OFS_CAPCMP);
   assign sel_mode   = (avs_req.address == OFS_MODE);
   assign sel_ccctrl = (avs_req.address == OFS_CCCTRL);
   assign sel_edge   = (avs_req.address == OFS_EDGE);
   assign full_half  = (avs_req.byteenable[1:0] == 2'h3);

   assign wr_capcmp  = wr_accept & sel_capcmp & full_half;
   assign wr_mode    = wr_accept & sel_mode & avs_req.byteenable[0];
   assign wr_ccctrl  = wr_accept & sel_ccctrl & avs_req.byteenable[0];
   assign wr_edge    = wr_accept & sel_edge & avs_req.byteenable[0];
   assign oneshot_trigger_bit = wr_mode & avs_req.writedata[MODE_TRIGGER_POS];

   // ---- control fields ----
   logic              op_enable_hi;
   logic              op_enable_lo;
   op_mode_type       op_mode;
   logic              running;
   logic              oneshot_mode;
   logic              capture_mode_select;
   logic              capture_source_select;
   logic              count_from_pin0;
   edge_sel_type      in0_edge_sel;
   edge_sel_type      in1_edge_sel;

   assign op_enable_hi          = mode_control_reg_r[MODE_OPEN_HI_POS];
   assign op_enable_lo          = mode_control_reg_r[MODE_OPEN_LO_POS];
   assign op_mode               = op_mode_type'({op_enable_hi, op_enable_lo});
   // run whenever enable bits are not 00
   assign running               = (op_mode != OP_STOP);
   assign oneshot_mode          = mode_control_reg_r[MODE_ONESHOT_POS];
   assign capture_mode_select   = cap_cmp_control_reg_r[CC_CAPTURE_POS];
   assign capture_source_select = cap_cmp_control_reg_r[CC_SOURCE_POS];
   assign count_from_pin0       = prescaler_edge_reg_r[EDGE_CLKSEL_POS];
   assign in0_edge_sel = edge_sel_type'(prescaler_edge_reg_r[EDGE_IN0_LO_POS +: 2]);
   assign in1_edge_sel = edge_sel_type'(prescaler_edge_reg_r[EDGE_IN1_LO_POS +: 2]);

   // ---- pin edge detection ----
   logic              pin0_rise;
   logic              pin0_fall;
   logic              pin1_rise;
   logic              pin1_fall;
   logic              in0_valid;
   logic              in0_cap_edge;
   logic              in1_valid;
   logic              capture_trig;

   assign pin0_rise = timer_in_pin0 & ~pin0_prev_r;
   assign pin0_fall = ~timer_in_pin0 & pin0_prev_r;
   assign pin1_rise = timer_in_pin1 & ~pin1_prev_r;
   assign pin1_fall = ~timer_in_pin1 & pin1_prev_r;

   // code 10 is left unprogrammed by software and detects nothing
   assign in0_valid = ((in0_edge_sel == EDGE_FALL) & pin0_fall)
                    | ((in0_edge_sel == EDGE_RISE) & pin0_rise)
                    | ((in0_edge_sel == EDGE_BOTH) & (pin0_rise | pin0_fall));

   // capture on the edge opposite the valid edge
   assign in0_cap_edge = ((in0_edge_sel == EDGE_RISE) & pin0_fall)
                       | ((in0_edge_sel == EDGE_FALL) & pin0_rise);

   // input 1 captures on its own valid edge
   assign in1_valid = ((in1_edge_sel == EDGE_FALL) & pin1_fall)
                    | ((in1_edge_sel == EDGE_RISE) & pin1_rise)
                    | ((in1_edge_sel == EDGE_BOTH) & (pin1_rise | pin1_fall));

   assign capture_trig = capture_source_select ? in0_cap_edge : in1_valid;

   // ---- count clock and freeze ----
   logic              src_tick;
   logic              freeze;
   logic              tick;
   logic              pending_nxt;

   assign src_tick = running & (count_from_pin0 ? in0_valid : 1'b1);
   // hold count clock during the snapshot cycle
   assign freeze   = rd_first & sel_count & running;
   assign tick     = running & ~freeze & (src_tick | tick_pending_r);
   assign pending_nxt = running & freeze & (src_tick | tick_pending_r);

   // ---- compare and clear ----
   logic              compare_mode;
   logic              at_compare;
   logic              match_evt;
   logic              clr_in0;
   logic              clr_match;
   logic              clr_oneshot;
   logic              clr_any;

   assign compare_mode = ~capture_mode_select;
   assign at_compare   = (count_value_r == first_cap_cmp_reg_r);

   // match when leaving the compare value, not the start value
   assign match_evt = compare_mode & tick & at_compare
                    & ~(fresh_start_r & (count_value_r == CNT_RESET));

   // clear on input 0 valid edge
   assign clr_in0     = (op_mode == OP_CLR_ON_IN0) & in0_valid;
   assign clr_match   = (op_mode == OP_CLR_ON_CMP) & compare_mode & tick & at_compare;
   assign clr_oneshot = running & oneshot_mode & (oneshot_trigger_bit | in0_valid);
   assign clr_any     = clr_in0 | clr_match | clr_oneshot;

   always_comb begin
      count_value_nxt = count_value_r;
      if (!running) begin
         count_value_nxt = CNT_RESET;
      end else if (clr_any) begin
         count_value_nxt = CNT_RESET;
      end else if (tick) begin
         count_value_nxt = count_value_r + 16'h0001;
      end
   end

   // capture only in capture mode; capture wins over a write
   always_comb begin
      first_cap_cmp_reg_nxt = first_cap_cmp_reg_r;
      if (wr_capcmp) begin
         first_cap_cmp_reg_nxt = avs_req.writedata[CNT_W-1:0];
      end
      if (capture_mode_select && capture_trig && running) begin
         first_cap_cmp_reg_nxt = count_value_r;
      end
   end

   // counter read only snapshots; nothing else is loaded
   always_comb begin
      readdata_nxt = '0;
      if (sel_count) begin
         readdata_nxt[CNT_W-1:0] = count_value_r;
      end else if (sel_capcmp) begin
         // read samples the register; a same-cycle capture lands after
         readdata_nxt[CNT_W-1:0] = first_cap_cmp_reg_r;
      end else if (sel_mode) begin
         readdata_nxt[7:0] = mode_control_reg_r & ~(8'h01 << MODE_TRIGGER_POS);
      end else if (sel_ccctrl) begin
         readdata_nxt[1:0] = cap_cmp_control_reg_r;
      end else if (sel_edge) begin
         readdata_nxt[7:0] = prescaler_edge_reg_r;
      end
   end

   // ---- bus handshake: wait one cycle, then answer ----
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         waitrequest_r <= 1'b1;
         readdata_r    <= '0;
      end else begin
         waitrequest_r <= ~(req_any & waitrequest_r);
         if (rd_first) begin
            readdata_r <= readdata_nxt;
         end
      end
   end

   // ---- control registers ----
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_control_reg_r    <= MODE_RESET;
         cap_cmp_control_reg_r <= CCCTRL_RESET;
         prescaler_edge_reg_r  <= EDGE_RESET;
      end else begin
         if (wr_mode) begin
            mode_control_reg_r <= avs_req.writedata[7:0] & ~(8'h01 << MODE_TRIGGER_POS);
         end
         if (wr_ccctrl) begin
            cap_cmp_control_reg_r <= avs_req.writedata[1:0];
         end
         if (wr_edge) begin
            prescaler_edge_reg_r <= avs_req.writedata[7:0];
         end
      end
   end

   // ---- counter, capture/compare, pins ----
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_value_r       <= CNT_RESET;
         first_cap_cmp_reg_r <= CAPCMP_RESET;
         tick_pending_r      <= 1'b0;
         pin0_prev_r         <= 1'b0;
         pin1_prev_r         <= 1'b0;
      end else begin
         count_value_r       <= count_value_nxt;
         first_cap_cmp_reg_r <= first_cap_cmp_reg_nxt;
         tick_pending_r      <= pending_nxt;
         pin0_prev_r         <= timer_in_pin0;
         pin1_prev_r         <= timer_in_pin1;
      end
   end

   // start marker suppresses a match leaving 0000 before the first count tick or clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fresh_start_r <= 1'b1;
      end else if (!running) begin
         fresh_start_r <= 1'b1;
      end else if (tick || clr_any) begin
         fresh_start_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= match_evt;
      end
   end

   assign avs_readdata    = readdata_r;
   assign avs_waitrequest = waitrequest_r;
   assign first_match_irq = irq_r;

endmodule

/* File: test/timer16_pin_model.sv */
// Purpose: external timer input pins seen by the core
// Assumes: pins are synchronous to clk
// Notes:   levels follow bench requests one edge later
`timescale 1ns/1ns
module timer16_pin_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [1:0] want,
   output      logic       timer_in_pin0,
   output      logic       timer_in_pin1
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_in_pin0 <= 1'b0;
         timer_in_pin1 <= 1'b0;
      end else begin
         timer_in_pin0 <= want[0];
         timer_in_pin1 <= want[1];
      end
   end
endmodule

/* File: test/timer16_capture_compare_core_props.sv */
// Purpose: port assertions for the timer core
// Assumes: one bus access in flight at a time
// Notes:   shadows follow mode and compare writes
`timescale 1ns/1ns
module timer16_core_props
   import timer16_pkg::*;
(
   input wire logic              clk,
   input wire logic              rst_n,
   input wire avs_req_type       avs_req,
   input wire logic [DATA_W-1:0] avs_readdata,
   input wire logic              avs_waitrequest,
   input wire logic              timer_in_pin0,
   input wire logic              timer_in_pin1,
   input wire logic              first_match_irq
);
   logic [1:0]       op_r;
   logic             cap_r;
   logic             held_r;
   logic [CNT_W-1:0] cmp_r;
   wire              rd   = avs_req.read & avs_waitrequest;
   wire              done = avs_req.write & ~avs_waitrequest;
   wire [ADDR_W-1:0] adr  = avs_req.address;
   wire              full = done & (adr == OFS_CAPCMP) & (&avs_req.byteenable[1:0]);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         op_r   <= 2'h0;
         cap_r  <= 1'b0;
         held_r <= 1'b1;
         cmp_r  <= CAPCMP_RESET;
      end else begin
         if (done && adr == OFS_MODE) op_r <= avs_req.writedata[3:2];
         if (done && adr == OFS_CCCTRL) cap_r <= avs_req.writedata[0];
         if (done && adr == OFS_CCCTRL && avs_req.writedata[0]) held_r <= 1'b0;
         if (full && !cap_r) held_r <= 1'b1;
         if (full) cmp_r <= avs_req.writedata[15:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_irq_one_cycle: assert property (first_match_irq |=> !first_match_irq)
      else $error("match pulse longer than one cycle");
   a_read_answer: assert property (rd |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("read not answered after one wait cycle");
   a_stop_zero: assert property (rd && adr == OFS_COUNT && op_r == 2'h0 |=> avs_readdata == '0)
      else $error("stopped counter not zero");
   a_stop_no_irq: assert property (op_r == 2'h0 && $past(op_r) == 2'h0 &&
      $past(op_r, 2) == 2'h0 |-> !first_match_irq)
      else $error("match request while stopped");
   a_trig_reads0: assert property (rd && adr == OFS_MODE |=> !avs_readdata[MODE_TRIGGER_POS])
      else $error("trigger bit read back as one");
   a_cmp_held: assert property (rd && adr == OFS_CAPCMP && held_r && !cap_r
      |=> avs_readdata == {16'h0, cmp_r})
      else $error("compare value not kept");
   a_irq_cmp_only: assert property (first_match_irq |-> !$past(cap_r) && !$past(cap_r, 2))
      else $error("match request in capture mode");
   a_count_width: assert property (rd && adr == OFS_COUNT |=> avs_readdata[31:16] == 16'h0)
      else $error("counter wider than sixteen bits");
   c_irq: cover property (first_match_irq);
   c_cap_read: cover property (rd && adr == OFS_CAPCMP && cap_r);
   c_run_read: cover property (rd && adr == OFS_COUNT && op_r != 2'h0);
endmodule
bind timer16_capture_compare_core timer16_core_props timer16_core_props_inst (
   .clk(clk), .rst_n(rst_n), .avs_req(avs_req), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .timer_in_pin0(timer_in_pin0),
   .timer_in_pin1(timer_in_pin1), .first_match_irq(first_match_irq));

/* File: test/timer16_capture_compare_core_tb.sv */
// Purpose: self-checking bench for the timer core
// Assumes: pin model delays pin requests by one edge
// Notes:   counting from pin 0 edges makes counts exact
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module timer16_capture_compare_core_tb
   import timer16_pkg::*;
;
   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   avs_req_type       req = '0;
   logic [DATA_W-1:0] rdata;
   logic              wreq;
   logic [1:0]        want = 2'h0;
   logic              pin0;
   logic              pin1;
   logic              irq;
   logic [DATA_W-1:0] q;
   int                num_errors = 0;
   int                tests_run = 0;
   int                irq_cnt = 0;
   always #5 clk = ~clk;
   always @(posedge clk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
   timer16_pin_model timer16_pin_model_inst (.clk(clk), .rst_n(rst_n), .want(want),
      .timer_in_pin0(pin0), .timer_in_pin1(pin1));
   timer16_capture_compare_core timer16_capture_compare_core_inst (.clk(clk), .rst_n(rst_n),
      .avs_req(req), .avs_readdata(rdata), .avs_waitrequest(wreq), .timer_in_pin0(pin0),
      .timer_in_pin1(pin1), .first_match_irq(irq));
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk);
      req <= '{read: ~wr, write: wr, address: a, writedata: d, byteenable: be};
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 100);
      q = rdata;
      req <= '0;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0, 4'hF);
      `CHK(nm, e, q)
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge clk);
         want[0] <= 1'b1;
         repeat (3) @(posedge clk);
         want[0] <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
   task automatic set_pin1(input logic v);
      @(posedge clk);
      want[1] <= v;
      repeat (4) @(posedge clk);
   endtask
   task automatic restart(input logic [7:0] e);
      wr(OFS_MODE, 32'h0);
      wr(OFS_CAPCMP, 32'hAA);
      wr(OFS_EDGE, {24'h0, e});
      wr(OFS_MODE, 32'h04);
   endtask
   task automatic t_basic();
      for (int a = 0; a <= 20; a += 4) rd_chk(a[ADDR_W-1:0], 32'h0, "reset");
      wr(OFS_EDGE, 32'h11);
      wr(OFS_MODE, 32'h04);
      pulse(5);
      rd_chk(OFS_COUNT, 32'h5, "count");
      rd_chk(OFS_CAPCMP, 32'h0, "no copy");
      wr(OFS_MODE, 32'h0);
      rd_chk(OFS_COUNT, 32'h0, "stop");
      bus(1'b1, OFS_CAPCMP, 32'h1234, 4'h1);
      rd_chk(OFS_CAPCMP, 32'h0, "part wr");
      wr(OFS_CAPCMP, 32'h5A5A0003);
      rd_chk(OFS_CAPCMP, 32'h3, "full wr");
   endtask
   task automatic t_clears();
      int n0;
      n0 = irq_cnt;
      wr(OFS_MODE, 32'h0C);
      pulse(5);
      rd_chk(OFS_COUNT, 32'h1, "clr match");
      `CHK("irq", 1, irq_cnt - n0)
      restart(8'h11);
      wr(OFS_MODE, 32'h0);
      wr(OFS_CAPCMP, 32'h3);
      wr(OFS_MODE, 32'h04);
      pulse(5);
      rd_chk(OFS_COUNT, 32'h5, "free");
      `CHK("irq free", 2, irq_cnt - n0)
      wr(OFS_MODE, 32'h0);
      wr(OFS_MODE, 32'h08);
      pulse(3);
      rd_chk(OFS_COUNT, 32'h0, "clr in0");
      wr(OFS_MODE, 32'h0);
      wr(OFS_EDGE, 32'h10);
      wr(OFS_MODE, 32'h14);
      repeat (50) @(posedge clk);
      wr(OFS_MODE, 32'h54);
      bus(1'b0, OFS_COUNT, 32'h0, 4'hF);
      `CHK("trigger", 1'b1, q < 32'h10)
      repeat (50) @(posedge clk);
      pulse(1);
      bus(1'b0, OFS_COUNT, 32'h0, 4'hF);
      `CHK("oneshot pin", 1'b1, q < 32'h10)
      rd_chk(OFS_MODE, 32'h14, "mode");
      wr(OFS_MODE, 32'h0);
   endtask
   task automatic t_capture();
      logic [7:0]  e0 [3] = '{8'h11, 8'h01, 8'h31};
      logic [31:0] x0 [3] = '{32'h3, 32'h2, 32'hAA};
      logic [7:0]  e1 [3] = '{8'h11, 8'h51, 8'hD1};
      logic [31:0] m1 [3] = '{32'hAA, 32'h1, 32'h1};
      logic [31:0] x1 [3] = '{32'h2, 32'h1, 32'h2};
      wr(OFS_CCCTRL, 32'h3);
      for (int i = 0; i < 3; i++) begin
         restart(e0[i]);
         pulse(3);
         rd_chk(OFS_CAPCMP, x0[i], "cap pin0");
      end
      wr(OFS_MODE, 32'h0);
      wr(OFS_CCCTRL, 32'h1);
      for (int i = 0; i < 3; i++) begin
         restart(e1[i]);
         pulse(1);
         set_pin1(1'b1);
         rd_chk(OFS_CAPCMP, m1[i], "cap pin1 mid");
         pulse(1);
         set_pin1(1'b0);
         rd_chk(OFS_CAPCMP, x1[i], "cap pin1 end");
      end
      wr(OFS_MODE, 32'h0);
      wr(OFS_CCCTRL, 32'h0);
      restart(8'hD1);
      pulse(1);
      set_pin1(1'b1);
      set_pin1(1'b0);
      rd_chk(OFS_CAPCMP, 32'hAA, "cmp ignore");
   endtask
   task automatic t_wrap();
      int          n0;
      logic [31:0] v;
      wr(OFS_MODE, 32'h0);
      wr(OFS_CAPCMP, 32'h0);
      wr(OFS_EDGE, 32'h0);
      n0 = irq_cnt;
      wr(OFS_MODE, 32'h04);
      repeat (100) @(posedge clk);
      `CHK("no early irq", 0, irq_cnt - n0)
      bus(1'b0, OFS_COUNT, 32'h0, 4'hF);
      v = q;
      bus(1'b0, OFS_COUNT, 32'h0, 4'hF);
      `CHK("run read", 1'b1, (q - v) inside {[2:4]})
      repeat (65536) @(posedge clk);
      `CHK("wrap irq", 1, irq_cnt - n0)
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_basic();
      t_clears();
      t_capture();
      t_wrap();
      give_verdict();
   end
   initial begin
      repeat (90000) @(posedge clk);
      num_errors++;
      give_verdict();
   end
endmodule
